// ---- inc/codec_spi_pkg.sv ----
// shared constants and types for the codec serial register port
package codec_spi_pkg;

  // ----------------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int NIBBLE_BITS = 4;
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 4;
  localparam int ADDR_MSB = 3;
  localparam int ADDR_LSB = 0;
  localparam logic [3:0] CMD_READ = 4'hA;
  localparam logic [3:0] CMD_WRITE = 4'hB;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------------------------------------
  // register space
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_MAX = 4'hA;
  localparam int NUM_REGS = 11;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [3:0] GPIO_DIR_ADDR = 4'h9;
  localparam logic [3:0] GPIO_DATA_ADDR = 4'hA;

  // ----------------------------------------------------------------------
  // reset timing
  // ----------------------------------------------------------------------
  localparam int RESET_DELAY_US = 20;
  localparam int REF_CLK_MHZ = 250;
  localparam int RESET_DELAY_CYC = RESET_DELAY_US * REF_CLK_MHZ;

  // ----------------------------------------------------------------------
  // link-side sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LK_CMD,
    LK_WR,
    LK_RD,
    LK_IGN
  } link_state_t;

endpackage

// ---- hdl/codec_reg_file.sv ----
// small register memory with synchronous clear and registered read data
`timescale 1ns/100ps
module codec_reg_file
  import codec_spi_pkg::*;
#(
  parameter int DW = BYTE_BITS,
  parameter int DEPTH = NUM_REGS,
  parameter int AW = NIBBLE_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);

  if (DEPTH > (1 << AW) || DW != BYTE_BITS) begin : g_bad_geometry
    $error("codec_reg_file: unsupported geometry");
  end

  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= REG_RESET_VAL;
      end
    end else if (ce) begin
      if (clr) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_q[i] <= REG_RESET_VAL;
        end
      end else if (we && int'(waddr) < DEPTH) begin
        mem_q[waddr] <= wdata;
      end
    end
  end

  // out-of-range reads return zero rather than x
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (ce && re) begin
      rdata_q <= (int'(raddr) < DEPTH) ? mem_q[raddr] : '0;
    end
  end

endmodule // codec_reg_file

// ---- hdl/reset_debounce.sv ----
// power-on reset stretcher and reset pin debouncer
`timescale 1ns/100ps
module reset_debounce
  import codec_spi_pkg::*;
#(
  parameter int DELAY_CYC = RESET_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rst_pin_n,
  output logic int_rst_q
);

  localparam int CW = $clog2(DELAY_CYC + 1);

  if (DELAY_CYC < 1) begin : g_bad_delay
    $error("reset_debounce: DELAY_CYC must be at least one");
  end

  logic pin_meta_q;
  logic pin_q;
  logic [CW-1:0] cnt_q;
  logic want_rst;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 1'b1;
      pin_q <= 1'b1;
    end else if (ce) begin
      pin_meta_q <= rst_pin_n;
      pin_q <= pin_meta_q;
    end
  end

  assign want_rst = ~pin_q;

  // the level must differ from the current state for the whole delay
  // before the state flips; this both stretches power-up and debounces
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_rst_q <= 1'b1;
      cnt_q <= '0;
    end else if (ce) begin
      if (want_rst == int_rst_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(DELAY_CYC - 1)) begin
        cnt_q <= '0;
        int_rst_q <= want_rst;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule // reset_debounce

// ---- hdl/codec_spi_register_port.sv ----
// serial register port of the voice codec, slave side
//
// Overview of operation
// - register access only while in pcm mode
// - data out high impedance unless driving read
// - command byte msb first: command, address
// - only read and write codes acted on
// - shift data in on rising clock edges
// - write code, valid address: store next byte
// - read code, valid address: return register
// - read data msb first on falling edges
// - reads report gpio input pin levels
// - address increments after each data byte
// - power-up and pin reset, debounced delay
// - valid addresses zero through ten only
`timescale 1ns/100ps
module codec_spi_register_port
  import codec_spi_pkg::*;
#(
  parameter int GPIO_W = 4,
  parameter int RST_DELAY_CYC = RESET_DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic rst_pin_n,
  input wire logic pcm_mode,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic [GPIO_W-1:0] gpio_in,
  output logic [GPIO_W-1:0] gpio_out,
  output logic [GPIO_W-1:0] gpio_oe,
  output logic int_rst,
  output logic reg_wr_stb,
  output logic [3:0] reg_wr_addr,
  output logic [7:0] reg_wr_data
);

  if (GPIO_W < 1 || GPIO_W > BYTE_BITS) begin : g_bad_gpio_w
    $error("codec_spi_register_port: GPIO_W must be 1 to 8");
  end

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic legal_addr(input logic [3:0] a);
    legal_addr = (a <= ADDR_MAX);
  endfunction

  // ----------------------------------------------------------------------
  // link domain: shift register and sequencer
  // ----------------------------------------------------------------------
  // a high select holds the link shift register, sequencer and data out in reset, so every frame
  // starts clean on the first rising edge after select falls
  logic link_rst;
  link_state_t state_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [3:0] addr_q;
  logic mode_meta_q;
  logic mode_ok_q;
  logic pcm_meta_q;
  logic pcm_q;
  logic [7:0] rx_byte;
  logic [3:0] next_addr;
  logic accept_rd;
  logic accept_wr;
  logic byte_done;

  // words handed across to the reference domain, held between toggles
  logic wr_tgl_q;
  logic [3:0] wr_addr_x_q;
  logic [7:0] wr_data_x_q;
  logic rd_tgl_q;
  logic [3:0] rd_addr_x_q;

  // read word from the reference domain
  logic [7:0] rd_word_q;

  assign link_rst = sys_rst | cs_n;

  always_comb begin
    rx_byte = {shift_q, sdi};
    next_addr = addr_q + 4'h1;
    byte_done = (bit_cnt_q == LAST_BIT);
    accept_rd = mode_ok_q && rx_byte[CMD_MSB:CMD_LSB] == CMD_READ
      && legal_addr(rx_byte[ADDR_MSB:ADDR_LSB]);
    accept_wr = mode_ok_q && rx_byte[CMD_MSB:CMD_LSB] == CMD_WRITE
      && legal_addr(rx_byte[ADDR_MSB:ADDR_LSB]);
  end

  // pcm mode level reaches the link through two flops of its own clock
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_meta_q <= 1'b0;
      mode_ok_q <= 1'b0;
    end else begin
      mode_meta_q <= pcm_q;
      mode_ok_q <= mode_meta_q;
    end
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      shift_q <= '0;
      bit_cnt_q <= '0;
    end else begin
      shift_q <= rx_byte[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      state_q <= LK_CMD;
      addr_q <= '0;
    end else if (byte_done) begin
      case (state_q)
        LK_CMD: begin
          addr_q <= rx_byte[ADDR_MSB:ADDR_LSB];
          if (accept_rd) begin
            state_q <= LK_RD;
          end else if (accept_wr) begin
            state_q <= LK_WR;
          end else begin
            state_q <= LK_IGN;
          end
        end
        LK_WR, LK_RD: begin
          addr_q <= next_addr;
          if (!legal_addr(next_addr)) begin
            state_q <= LK_IGN;
          end
        end
        LK_IGN: state_q <= LK_IGN;
        default: state_q <= LK_IGN;
      endcase
    end
  end

  // toggles stay alive across frames: resetting them on select would
  // look like a spurious event to the other domain
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_tgl_q <= 1'b0;
      wr_addr_x_q <= '0;
      wr_data_x_q <= '0;
    end else if (!cs_n && byte_done && state_q == LK_WR) begin
      wr_addr_x_q <= addr_q;
      wr_data_x_q <= rx_byte;
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_tgl_q <= 1'b0;
      rd_addr_x_q <= '0;
    end else if (!cs_n && byte_done) begin
      if (state_q == LK_CMD && accept_rd) begin
        rd_addr_x_q <= rx_byte[ADDR_MSB:ADDR_LSB];
        rd_tgl_q <= ~rd_tgl_q;
      end else if (state_q == LK_RD && legal_addr(next_addr)) begin
        rd_addr_x_q <= next_addr;
        rd_tgl_q <= ~rd_tgl_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // link domain: data out on falling edges
  // ----------------------------------------------------------------------
  // the read word must be settled half a serial clock after the request;
  // the reference side answers in three to four of its cycles, well inside
  // the shortest allowed serial clock phase
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (state_q == LK_RD) begin
      sdo <= rd_word_q[LAST_BIT - bit_cnt_q];
      sdo_oe <= 1'b1;
    end else begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // reference domain: synchronisers
  // ----------------------------------------------------------------------
  logic [GPIO_W-1:0] gpio_meta_q;
  logic [GPIO_W-1:0] gpio_sync_q;
  logic [2:0] wr_sync_q;
  logic [2:0] rd_sync_q;
  logic wr_evt;
  logic rd_evt;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcm_meta_q <= 1'b0;
      pcm_q <= 1'b0;
      gpio_meta_q <= '0;
      gpio_sync_q <= '0;
    end else if (clk_en) begin
      pcm_meta_q <= pcm_mode;
      pcm_q <= pcm_meta_q;
      gpio_meta_q <= gpio_in;
      gpio_sync_q <= gpio_meta_q;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_sync_q <= '0;
      rd_sync_q <= '0;
    end else if (clk_en) begin
      wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
      rd_sync_q <= {rd_sync_q[1:0], rd_tgl_q};
    end
  end
  assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
  assign rd_evt = rd_sync_q[2] ^ rd_sync_q[1];

  // ----------------------------------------------------------------------
  // reference domain: reset, registers and write path
  // ----------------------------------------------------------------------
  logic int_rst_w;
  logic wr_go;
  logic [7:0] mem_rdata;
  logic [GPIO_W-1:0] gpio_dir_q;
  logic [GPIO_W-1:0] gpio_dat_q;
  logic rd_pend_q;
  logic [7:0] gpio_rd;

  reset_debounce #(
    .DELAY_CYC(RST_DELAY_CYC)
  ) u_reset (
    .clk(ref_clk),
    .rst(sys_rst),
    .ce(clk_en),
    .rst_pin_n(rst_pin_n),
    .int_rst_q(int_rst_w)
  );
  assign int_rst = int_rst_w;
  // writes need the device out of reset and in pcm mode
  assign wr_go = wr_evt && pcm_q && !int_rst_w;

  codec_reg_file #(
    .DW(BYTE_BITS),
    .DEPTH(NUM_REGS),
    .AW(NIBBLE_BITS)
  ) u_regs (
    .clk(ref_clk),
    .rst(sys_rst),
    .ce(clk_en),
    .clr(int_rst_w),
    .we(wr_go),
    .waddr(wr_addr_x_q),
    .wdata(wr_data_x_q),
    .re(rd_evt),
    .raddr(rd_addr_x_q),
    .rdata_q(mem_rdata)
  );

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_wr_stb <= 1'b0;
      reg_wr_addr <= '0;
      reg_wr_data <= '0;
    end else if (clk_en) begin
      reg_wr_stb <= wr_go;
      if (wr_go) begin
        reg_wr_addr <= wr_addr_x_q;
        reg_wr_data <= wr_data_x_q;
      end
    end
  end

  // direction bit high means the pin is an input
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpio_dir_q <= '0;
      gpio_dat_q <= '0;
    end else if (clk_en) begin
      if (int_rst_w) begin
        gpio_dir_q <= '0;
        gpio_dat_q <= '0;
      end else if (wr_go && wr_addr_x_q == GPIO_DIR_ADDR) begin
        gpio_dir_q <= wr_data_x_q[GPIO_W-1:0];
      end else if (wr_go && wr_addr_x_q == GPIO_DATA_ADDR) begin
        gpio_dat_q <= wr_data_x_q[GPIO_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpio_out <= '0;
      gpio_oe <= '0;
    end else if (clk_en) begin
      gpio_out <= gpio_dat_q;
      gpio_oe <= ~gpio_dir_q;
    end
  end

  // ----------------------------------------------------------------------
  // reference domain: read path
  // ----------------------------------------------------------------------
  // input pins show their live level, output pins the stored value
  always_comb begin
    gpio_rd = mem_rdata;
    for (int i = 0; i < GPIO_W; i++) begin
      gpio_rd[i] = gpio_dir_q[i] ? gpio_sync_q[i] : mem_rdata[i];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_q <= 1'b0;
      rd_word_q <= '0;
    end else if (clk_en) begin
      rd_pend_q <= rd_evt;
      if (rd_pend_q) begin
        if (rd_addr_x_q == GPIO_DATA_ADDR) begin
          rd_word_q <= gpio_rd;
        end else begin
          rd_word_q <= mem_rdata;
        end
      end
    end
  end

endmodule // codec_spi_register_port

// ---- tb/codec_spi_monitor.sv ----
// assertion checker for the codec serial register port
`timescale 1ns/100ps
module codec_spi_monitor
  import codec_spi_pkg::*;
#(
  parameter int RST_DELAY_CYC = RESET_DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rst_pin_n,
  input wire logic pcm_mode,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_oe,
  input wire logic int_rst,
  input wire logic reg_wr_stb,
  input wire logic [3:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data
);
  // ----------------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------------
  logic [7:0] bit_cnt_q;
  logic [7:0] shift_q;
  int pin_low_q;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 8'h00;
      shift_q <= 8'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 8'h01;
      shift_q <= {shift_q[6:0], sdi};
    end
  end
  // saturates so a long pin hold never wraps the count
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) pin_low_q <= 0;
    else if (rst_pin_n) pin_low_q <= 0;
    else if (pin_low_q < 100000) pin_low_q <= pin_low_q + 1;
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  sequence s_cmd_byte;
    bit_cnt_q == 8'h08;
  endsequence
  sequence s_read_ok;
    shift_q[7:4] == CMD_READ && shift_q[3:0] <= ADDR_MAX;
  endsequence
  property p_rd_start;
    @(posedge sclk) disable iff (sys_rst || cs_n)
      $rose(sdo_oe) |-> s_cmd_byte and s_read_ok;
  endproperty
  property p_bad_cmd;
    @(posedge sclk) disable iff (sys_rst || cs_n)
      (bit_cnt_q == 8'h08 && !(shift_q[7:4] == CMD_READ
        && shift_q[3:0] <= ADDR_MAX)) |-> !sdo_oe [*4];
  endproperty
  property p_oe_hold;
    @(posedge sclk) disable iff (sys_rst || cs_n)
      (sdo_oe && bit_cnt_q[2:0] != 3'h7) |=> sdo_oe;
  endproperty
  property p_hiz_idle;
    @(posedge ref_clk) disable iff (sys_rst)
      (cs_n && $past(cs_n)) |-> !sdo_oe;
  endproperty
  property p_stb_pulse;
    @(posedge ref_clk) disable iff (sys_rst) reg_wr_stb |=> !reg_wr_stb;
  endproperty
  property p_wr_stable;
    @(posedge ref_clk) disable iff (sys_rst)
      ($changed(reg_wr_addr) || $changed(reg_wr_data))
        |-> (reg_wr_stb || $past(reg_wr_stb));
  endproperty
  property p_wr_addr_ok;
    @(posedge ref_clk) disable iff (sys_rst)
      reg_wr_stb |-> reg_wr_addr <= ADDR_MAX;
  endproperty
  property p_rst_blocks;
    @(posedge ref_clk) disable iff (sys_rst) int_rst [*3] |-> !reg_wr_stb;
  endproperty
  property p_pcm_blocks;
    @(posedge ref_clk) disable iff (sys_rst) !pcm_mode [*8] |-> !reg_wr_stb;
  endproperty
  property p_pin_reset;
    @(posedge ref_clk) disable iff (sys_rst)
      pin_low_q > RST_DELAY_CYC + 6 |-> int_rst;
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read output started off a command boundary");
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("data out driven after a refused command");
  a_oe_hold: assert property (p_oe_hold)
    else $error("data out released inside a byte");
  a_hiz_idle: assert property (p_hiz_idle)
    else $error("data out driven while deselected");
  a_stb_pulse: assert property (p_stb_pulse)
    else $error("write strobe longer than one cycle");
  a_wr_stable: assert property (p_wr_stable)
    else $error("write address or data moved without a strobe");
  a_wr_addr_ok: assert property (p_wr_addr_ok)
    else $error("write to an address above the register range");
  a_rst_blocks: assert property (p_rst_blocks)
    else $error("write strobe during internal reset");
  a_pcm_blocks: assert property (p_pcm_blocks)
    else $error("write strobe outside pcm mode");
  a_pin_reset: assert property (p_pin_reset)
    else $error("reset pin held low without internal reset");
endmodule // codec_spi_monitor

bind codec_spi_register_port codec_spi_monitor #(
  .RST_DELAY_CYC(RST_DELAY_CYC)
) u_monitor (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
  .pcm_mode(pcm_mode), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
  .sdo_oe(sdo_oe), .int_rst(int_rst), .reg_wr_stb(reg_wr_stb),
  .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data)
);

// ---- tb/serial_master.sv ----
// serial bus master model that talks to the codec register port
`timescale 1ns/100ps
module serial_master (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo_line
);
  logic lclk;
  // free 15 ns base clock; sclk is stepped by the tasks on its edges and idles low
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #7.5 lclk = ~lclk;
  end
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b1;
  end
  // four base periods a phase: the port needs time to fetch read data
  task automatic half();
    repeat (4) @(posedge lclk);
  endtask
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      half();
      sclk = 1'b1;
      rx[i] = sdo_line;
      half();
      sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, d0, d1, input int nd,
                       output logic [7:0] r0, r1);
    logic [7:0] dummy;
    cs_n = 1'b0;
    half();
    xbyte(cmd, dummy);
    if (nd > 0) xbyte(d0, r0);
    if (nd > 1) xbyte(d1, r1);
    half();
    cs_n = 1'b1;
    sdi = ~sdi;
    half();
  endtask
endmodule // serial_master

// ---- tb/codec_spi_register_port_bench.sv ----
// self-checking bench for the codec serial register port
`timescale 1ns/100ps
module codec_spi_register_port_bench;
  import codec_spi_pkg::*;
  localparam int DLY = 8;
  logic ref_clk, sys_rst, clk_en, rst_pin_n, pcm_mode;
  logic sclk, cs_n, sdi, sdo, sdo_oe, int_rst, reg_wr_stb;
  logic [3:0] gpio_in, gpio_out, gpio_oe, reg_wr_addr;
  logic [7:0] reg_wr_data, r0, r1;
  int err_count, comparisons, cycles, wr_cnt;
  tri1 sdo_line;
  assign sdo_line = sdo_oe ? sdo : 1'bz;
  codec_spi_register_port #(.GPIO_W(4), .RST_DELAY_CYC(DLY)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .rst_pin_n(rst_pin_n), .pcm_mode(pcm_mode), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .int_rst(int_rst), .reg_wr_stb(reg_wr_stb),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data)
  );
  serial_master u_master (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line)
  );
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // strobe is counted mid-cycle, away from the edge that launches it
  always @(negedge ref_clk) begin
    cycles++;
    if (reg_wr_stb === 1'b1) wr_cnt++;
    if (cycles == 60000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d0, d1,
                    input int nd);
    u_master.frame({CMD_WRITE, a}, d0, d1, nd, r0, r1);
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input int nd);
    u_master.frame({CMD_READ, a}, 8'hFF, 8'hFF, nd, r0, r1);
  endtask
  task automatic t_write();
    int n0;
    n0 = wr_cnt;
    wr(4'h5, 8'h3C, 8'h00, 1);
    check("write count", 8'(wr_cnt - n0), 8'h01);
    check("write addr", {4'h0, reg_wr_addr}, 8'h05);
    check("write data", reg_wr_data, 8'h3C);
    rd(4'h5, 1);
    check("read 5", r0, 8'h3C);
    wr(4'h3, 8'h11, 8'h22, 2);
    check("burst addr", {4'h0, reg_wr_addr}, 8'h04);
    rd(4'h3, 2);
    check("burst 3", r0, 8'h11);
    check("burst 4", r1, 8'h22);
    $display("test write and read done");
  endtask
  task automatic t_refuse();
    int n0;
    n0 = wr_cnt;
    for (int c = 0; c < 16; c++) begin
      if (c == 10 || c == 11) continue;
      u_master.frame({4'(c), 4'h5}, 8'h77, 8'h00, 1, r0, r1);
      check("bad cmd out", r0, 8'hFF);
    end
    rd(4'hC, 1);
    check("bad addr out", r0, 8'hFF);
    wr(4'hA, 8'h50, 8'h99, 2);
    check("refused count", 8'(wr_cnt - n0), 8'h01);
    rd(4'h5, 1);
    check("kept", r0, 8'h3C);
    $display("test refusals done");
  endtask
  task automatic t_gpio();
    @(negedge ref_clk);
    gpio_in = 4'h6;
    wr(GPIO_DIR_ADDR, 8'h0F, 8'h00, 1);
    check("gpio oe in", {4'h0, gpio_oe}, 8'h00);
    rd(GPIO_DATA_ADDR, 1);
    check("gpio read", r0, 8'h56);
    wr(GPIO_DATA_ADDR, 8'h59, 8'h00, 1);
    wr(GPIO_DIR_ADDR, 8'h00, 8'h00, 1);
    check("gpio oe out", {4'h0, gpio_oe}, 8'h0F);
    check("gpio out", {4'h0, gpio_out}, 8'h09);
    rd(GPIO_DATA_ADDR, 1);
    check("gpio stored", r0, 8'h59);
    $display("test gpio done");
  endtask
  // a write made while the reference clock is held lands once it runs
  task automatic t_freeze();
    int n0;
    @(negedge ref_clk);
    clk_en = 1'b0;
    n0 = wr_cnt;
    wr(4'h2, 8'h5A, 8'h00, 1);
    check("frozen count", 8'(wr_cnt - n0), 8'h00);
    @(negedge ref_clk);
    clk_en = 1'b1;
    repeat (10) @(negedge ref_clk);
    check("thawed count", 8'(wr_cnt - n0), 8'h01);
    rd(4'h2, 1);
    check("thawed reg", r0, 8'h5A);
    $display("test clock enable done");
  endtask
  task automatic t_pcm();
    int n0;
    @(negedge ref_clk);
    pcm_mode = 1'b0;
    n0 = wr_cnt;
    wr(4'h1, 8'hAA, 8'h00, 1);
    rd(4'h1, 1);
    check("pcm off read", r0, 8'hFF);
    check("pcm off count", 8'(wr_cnt - n0), 8'h00);
    @(negedge ref_clk);
    pcm_mode = 1'b1;
    rd(4'h1, 1);
    check("pcm off reg", r0, REG_RESET_VAL);
    $display("test pcm mode done");
  endtask
  task automatic t_pin();
    @(negedge ref_clk);
    rst_pin_n = 1'b0;
    repeat (DLY - 3) @(negedge ref_clk);
    rst_pin_n = 1'b1;
    repeat (DLY + 10) @(negedge ref_clk);
    check("pin glitch", {7'h00, int_rst}, 8'h00);
    rst_pin_n = 1'b0;
    repeat (DLY + 10) @(negedge ref_clk);
    check("pin reset", {7'h00, int_rst}, 8'h01);
    rst_pin_n = 1'b1;
    repeat (DLY + 10) @(negedge ref_clk);
    check("pin release", {7'h00, int_rst}, 8'h00);
    rd(4'h5, 1);
    check("cleared", r0, REG_RESET_VAL);
    $display("test reset pin done");
  endtask
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    rst_pin_n = 1'b1;
    pcm_mode = 1'b1;
    gpio_in = 4'h0;
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (DLY + 10) @(negedge ref_clk);
    check("power-up", {7'h00, int_rst}, 8'h00);
    t_write();
    t_refuse();
    t_gpio();
    t_pcm();
    t_freeze();
    t_pin();
    wrap_up();
  end
endmodule // codec_spi_register_port_bench
